/* pkg/spw_core_if.sv */
// Interface carrying events and timer handshake between block modules
`timescale 1ns/1ps
interface spw_core_if;
    import spw_pkg::*;
    logic [SPW_N_EVT-1:0]   evt_fall;
    logic                   tmr_start;
    logic [SPW_DELAY_W-1:0] tmr_code;
    logic                   tmr_busy;
    logic                   tmr_done;

    modport edge_src (output evt_fall);
    modport core     (input evt_fall, output tmr_start, output tmr_code,
                      input tmr_busy, input tmr_done);
    modport timer    (input tmr_start, input tmr_code,
                      output tmr_busy, output tmr_done);
endinterface

/* pkg/spw_pkg.sv */
// Package with constants of the soft power wake and delay block
// ======================================================================
// Overview of operation
// [R1] - Status bits read 1 after their event, 0 since last cleared.
// [R2] - Bit 0 latches a falling edge on UART A receive data; read clears.
// [R3] - Bit 1 latches a falling edge on UART B receive data; read clears.
// [R4] - Bit 3 latches ring input; if enabled it also activates power-on.
// [R5] - Bit 2 latches button press; read clears; latch never feeds power-down.
// [R6] - Power-off delay is programmable from 500 ms up to 32 s.
// [R7] - After reset the power-off delay is 500 ms.
// [R8] - Delay starts on button press only with power-off and delay enabled.
// [R9] - Delay field is bits 5:0; delay equals (code plus one) times 500 ms.
// [R10] - Delay lasts at least nominal time, at most 10 ms longer.
// [R11] - Per-source wake enables gate UART A, UART B and ring wake.
// [R12] - Button power-off enable defaults to 1 and is software writable.
// [R13] - An event in the same cycle as a status read stays latched.
package spw_pkg;

    // ==================================================================
    // Register map, word index; byte address is four times the index
    localparam int          SPW_ADR_W      = 10;
    localparam logic [7:0]  SPW_IDX_ENABLE = 8'hB1;
    localparam logic [7:0]  SPW_IDX_STATUS = 8'hB3;
    localparam logic [7:0]  SPW_IDX_DELAY  = 8'hB8;
    localparam logic [7:0]  SPW_IDX_CTRL   = 8'hB9;

    // ==================================================================
    // Field positions; event index equals status bit position
    localparam int          SPW_N_EVT      = 4;
    localparam int          SPW_EVT_UART_A = 0;
    localparam int          SPW_EVT_UART_B = 1;
    localparam int          SPW_EVT_BUTTON = 2;
    localparam int          SPW_EVT_RING   = 3;
    localparam int          SPW_EN_UART_A  = 0;
    localparam int          SPW_EN_UART_B  = 1;
    localparam int          SPW_EN_RING    = 3;
    localparam int          SPW_EN_OFF     = 7;
    localparam int          SPW_CTRL_SEL   = 0;
    localparam int          SPW_CTRL_BUSY  = 1;
    localparam int          SPW_CTRL_PWR   = 2;
    localparam int          SPW_DELAY_W    = 6;

    // ==================================================================
    // Reset values
    localparam logic [7:0]  SPW_ENABLE_RST = 8'h80;
    localparam logic [3:0]  SPW_STATUS_RST = 4'h0;
    localparam logic [5:0]  SPW_DELAY_RST  = 6'h00;
    localparam logic        SPW_CTRL_RST   = 1'b0;

    // ==================================================================
    // Timing
    localparam int          SPW_CLK_MHZ    = 250;
    localparam int          SPW_STEP_MS    = 500;
    localparam int          SPW_SLACK_MS   = 10;
    localparam int unsigned SPW_STEP_CYCLES =
        SPW_STEP_MS * SPW_CLK_MHZ * 1000;
    localparam int          SPW_TICK_W     = 32;

endpackage

/* src/spw_delay_timer.sv */
// Power-off delay timer counting 500 ms steps
`timescale 1ns/1ps
module spw_delay_timer #(
    parameter int unsigned STEP_CYCLES = spw_pkg::SPW_STEP_CYCLES
) (
    input  wire logic    clk_i,
    input  wire logic    rst_i,
    spw_core_if.timer    t
);
    import spw_pkg::*;

    // Exact nominal length, well inside the allowed slack [R10]
    localparam logic [SPW_TICK_W-1:0] LAST = SPW_TICK_W'(STEP_CYCLES - 1);

    typedef struct packed {
        logic                   busy;
        logic                   done;
        logic [SPW_DELAY_W-1:0] code;
        logic [SPW_DELAY_W-1:0] step;
        logic [SPW_TICK_W-1:0]  cnt;
        logic [39:0]            elapsed;
    } spw_tmr_s;

    spw_tmr_s cur;
    spw_tmr_s next_cur;

    // ==================================================================
    // Code is captured at start; later writes affect only the next delay
    always_comb begin
        next_cur      = cur;
        next_cur.done = 1'b0;
        if (!cur.busy) begin
            if (t.tmr_start) begin
                next_cur.busy    = 1'b1;
                next_cur.code    = t.tmr_code;
                next_cur.step    = '0;
                next_cur.cnt     = '0;
                next_cur.elapsed = '0;
            end
        end else begin
            next_cur.elapsed = 40'(cur.elapsed + 40'd1);
            if (cur.cnt == LAST) begin
                next_cur.cnt = '0;
                if (cur.step == cur.code) begin // [R9]
                    next_cur.busy = 1'b0;
                    next_cur.done = 1'b1;
                end else begin
                    next_cur.step = SPW_DELAY_W'(cur.step + 1'b1);
                end
            end else begin
                next_cur.cnt = SPW_TICK_W'(cur.cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign t.tmr_busy = cur.busy;
    assign t.tmr_done = cur.done;

    // ==================================================================
    // Checks
    expire_time_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R10]
        $rose(cur.done) |-> cur.elapsed ==
            40'(({34'h0, cur.code} + 40'h1) * 40'(STEP_CYCLES)))
        else $error("delay length differs from code times step");
    busy_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
        cur.busy && !cur.done |=> cur.busy || cur.done)
        else $error("timer left busy without done");
endmodule

/* src/spw_sync_edge.sv */
// Pin synchronisers with falling edge detection
`timescale 1ns/1ps
module spw_sync_edge #(
    parameter int N = spw_pkg::SPW_N_EVT
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] pin_i,
    spw_core_if.edge_src      ev
);
    import spw_pkg::*;

    typedef struct packed {
        logic [N-1:0] meta;
        logic [N-1:0] sync;
        logic [N-1:0] last;
        logic [N-1:0] fall;
    } spw_sync_s;

    spw_sync_s cur;
    spw_sync_s next_cur;

    // ==================================================================
    // Idle level is high, so reset to ones to avoid a false edge
    always_comb begin
        next_cur      = cur;
        next_cur.meta = pin_i;
        next_cur.sync = cur.meta;
        next_cur.last = cur.sync;
        next_cur.fall = cur.last & ~cur.sync;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '{meta: '1, sync: '1, last: '1, fall: '0};
        end else begin
            cur <= next_cur;
        end
    end

    assign ev.evt_fall = cur.fall;
endmodule

/* src/spw_top.sv */
// Soft power wake status, wake enables and power-off delay with Wishbone
`timescale 1ns/1ps
module spw_top #(
    parameter int unsigned STEP_CYCLES = spw_pkg::SPW_STEP_CYCLES
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [spw_pkg::SPW_ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output wire logic [31:0]                  wb_dat_o,
    output wire logic                         wb_ack_o,
    input  wire logic                         uart_a_rxd_i,
    input  wire logic                         uart_b_rxd_i,
    input  wire logic                         power_button_n_i,
    input  wire logic                         ring_indicator_pin_n_i,
    output wire logic                         power_on_request_n_o
);
    import spw_pkg::*;

    // ==================================================================
    // State
    typedef struct packed {
        logic                   ack;
        logic [7:0]             dat;
        logic [SPW_N_EVT-1:0]   status;
        logic                   uart_a_rx_wake_enable;
        logic                   uart_b_rx_wake_enable;
        logic                   ring_wake_enable;
        logic                   off_enable;
        logic [SPW_DELAY_W-1:0] delay;
        logic                   poweroff_delay_select;
        logic                   power_on;
    } spw_top_s;

    spw_top_s cur;
    spw_top_s next_cur;

    spw_core_if c ();

    // ==================================================================
    // Submodules
    spw_sync_edge #(
        .N (SPW_N_EVT)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pin_i ({ring_indicator_pin_n_i, power_button_n_i,
                 uart_b_rxd_i, uart_a_rxd_i}),
        .ev    (c.edge_src)
    );

    spw_delay_timer #(
        .STEP_CYCLES (STEP_CYCLES)
    ) u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .t     (c.timer)
    );

    // ==================================================================
    // Register read decode
    function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                            input spw_top_s s);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            SPW_IDX_ENABLE: begin
                v[SPW_EN_UART_A] = s.uart_a_rx_wake_enable;
                v[SPW_EN_UART_B] = s.uart_b_rx_wake_enable;
                v[SPW_EN_RING]   = s.ring_wake_enable;
                v[SPW_EN_OFF]    = s.off_enable;
            end
            SPW_IDX_STATUS: begin
                v[SPW_N_EVT-1:0] = s.status; // [R1]
            end
            SPW_IDX_DELAY: begin
                v[SPW_DELAY_W-1:0] = s.delay;
            end
            SPW_IDX_CTRL: begin
                v[SPW_CTRL_SEL] = s.poweroff_delay_select;
                v[SPW_CTRL_PWR] = s.power_on;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return v;
    endfunction

    logic       req;
    logic       wr;
    logic       rd_stat;
    logic [7:0] idx;
    logic       wake;

    assign idx     = wb_adr_i[SPW_ADR_W-1:2];
    assign req     = wb_cyc_i & wb_stb_i & ~cur.ack;
    assign wr      = req & wb_we_i & wb_sel_i[0];
    assign rd_stat = req & ~wb_we_i & (idx == SPW_IDX_STATUS);

    // Button wakes only a system that is off; on one that is on it can only start the delay
    assign wake =
        (c.evt_fall[SPW_EVT_UART_A] & cur.uart_a_rx_wake_enable) | // [R11]
        (c.evt_fall[SPW_EVT_UART_B] & cur.uart_b_rx_wake_enable) | // [R11]
        (c.evt_fall[SPW_EVT_RING]   & cur.ring_wake_enable)      | // [R4]
        (c.evt_fall[SPW_EVT_BUTTON] & ~cur.power_on);

    // Busy timer ignores further presses, so a second press cannot extend
    assign c.tmr_start = c.evt_fall[SPW_EVT_BUTTON] & cur.power_on &
                         cur.off_enable & cur.poweroff_delay_select; // [R8]
    assign c.tmr_code  = cur.delay; // [R9]

    // ==================================================================
    // Next state
    always_comb begin
        next_cur     = cur;
        next_cur.ack = req;
        if (req) begin
            next_cur.dat = wb_we_i ? 8'h00 : reg_read(idx, cur);
        end
        // Set after clear so a same-cycle event survives the read
        next_cur.status = cur.status & ~{SPW_N_EVT{rd_stat}}; // [R1]
        next_cur.status = next_cur.status | c.evt_fall; // [R2] [R3] [R5] [R13]
        if (wr) begin
            case (idx)
                SPW_IDX_ENABLE: begin
                    next_cur.uart_a_rx_wake_enable =
                        wb_dat_i[SPW_EN_UART_A]; // [R11]
                    next_cur.uart_b_rx_wake_enable =
                        wb_dat_i[SPW_EN_UART_B]; // [R11]
                    next_cur.ring_wake_enable = wb_dat_i[SPW_EN_RING];
                    next_cur.off_enable = wb_dat_i[SPW_EN_OFF]; // [R12]
                end
                SPW_IDX_DELAY: begin
                    next_cur.delay = wb_dat_i[SPW_DELAY_W-1:0]; // [R6]
                end
                SPW_IDX_CTRL: begin
                    next_cur.poweroff_delay_select = wb_dat_i[SPW_CTRL_SEL];
                end
                default: begin
                    next_cur.delay = cur.delay;
                end
            endcase
        end
        // Wake wins over an expiring delay in the same cycle
        if (c.tmr_done) begin
            next_cur.power_on = 1'b0;
        end
        if (wake) begin
            next_cur.power_on = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur.ack                   <= 1'b0;
            cur.dat                   <= 8'h00;
            cur.status                <= SPW_STATUS_RST;
            cur.uart_a_rx_wake_enable <= SPW_ENABLE_RST[SPW_EN_UART_A];
            cur.uart_b_rx_wake_enable <= SPW_ENABLE_RST[SPW_EN_UART_B];
            cur.ring_wake_enable      <= SPW_ENABLE_RST[SPW_EN_RING];
            cur.off_enable            <= SPW_ENABLE_RST[SPW_EN_OFF]; // [R12]
            cur.delay                 <= SPW_DELAY_RST; // [R7]
            cur.poweroff_delay_select <= SPW_CTRL_RST;
            cur.power_on              <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // ==================================================================
    // Outputs; busy is read live so software sees the running delay
    assign wb_ack_o = cur.ack;
    assign wb_dat_o = {24'h000000, cur.dat[7:SPW_CTRL_BUSY+1],
                       cur.dat[SPW_CTRL_BUSY] |
                       (cur.ack & (idx == SPW_IDX_CTRL) & c.tmr_busy),
                       cur.dat[SPW_CTRL_BUSY-1:0]};
    assign power_on_request_n_o = ~cur.power_on; // [R4]

    // ==================================================================
    // Checks
    uart_a_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        c.evt_fall[SPW_EVT_UART_A] |=> cur.status[SPW_EVT_UART_A]) // [R2]
        else $error("UART A edge not latched");
    uart_b_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        c.evt_fall[SPW_EVT_UART_B] |=> cur.status[SPW_EVT_UART_B]) // [R3]
        else $error("UART B edge not latched");
    button_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        c.evt_fall[SPW_EVT_BUTTON] |=> cur.status[SPW_EVT_BUTTON]) // [R5]
        else $error("button press not latched");
    ring_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        c.evt_fall[SPW_EVT_RING] && cur.ring_wake_enable
        |=> cur.status[SPW_EVT_RING] && !power_on_request_n_o) // [R4]
        else $error("ring event did not latch and wake");
    read_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_stat && c.evt_fall == '0 |=> cur.status == '0 ##1
        wb_dat_o[SPW_N_EVT-1:0] == $past(cur.status, 2)) // [R1]
        else $error("status read did not clear or return old value");
    set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_stat && c.evt_fall[SPW_EVT_UART_A]
        |=> cur.status[SPW_EVT_UART_A]) // [R13]
        else $error("event lost during status read");
    wake_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cur.power_on && !cur.uart_a_rx_wake_enable && !c.tmr_done &&
        c.evt_fall == (4'h1 << SPW_EVT_UART_A)
        |=> power_on_request_n_o) // [R11]
        else $error("disabled UART A event woke the system");
    reset_value_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> cur.delay == SPW_DELAY_RST &&
        cur.off_enable) // [R7]
        else $error("delay or power-off enable wrong after reset");
    delay_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        c.evt_fall[SPW_EVT_BUTTON] && cur.power_on && cur.off_enable &&
        cur.poweroff_delay_select && !c.tmr_busy |=> c.tmr_busy) // [R8]
        else $error("power-off delay did not start");
    off_disabled_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cur.off_enable && !c.tmr_busy |=> !c.tmr_busy) // [R12]
        else $error("delay started with power-off disabled");
    delay_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wr && idx == SPW_IDX_DELAY
        |=> cur.delay == $past(wb_dat_i[SPW_DELAY_W-1:0])) // [R9]
        else $error("delay field not written");
    expiry_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        c.tmr_done && !wake |=> power_on_request_n_o) // [R6]
        else $error("delay expiry did not power off");
endmodule

/* verification/spw_pin_model.sv */
// Wake pins model: two receive lines, power button and ring input
`timescale 1ns/1ps
module spw_pin_model #(
    parameter int LOW_CYC = 6
) (
    input  wire logic       clk_i,
    input  wire logic [3:0] pulse_i,
    output logic      [3:0] pin_n_o
);
    int cnt [4];

    // ==================================================================
    // Pins idle high like pulled-up lines; a pulse request pulls one low
    initial begin
        pin_n_o = 4'hF;
        foreach (cnt[k]) cnt[k] = 0;
    end

    always @(posedge clk_i) begin
        for (int k = 0; k < 4; k++) begin
            if (pulse_i[k]) begin
                cnt[k] <= LOW_CYC;
                pin_n_o[k] <= 1'b0;
            end else if (cnt[k] > 1) begin
                cnt[k] <= cnt[k] - 1;
            end else begin
                cnt[k] <= 0;
                pin_n_o[k] <= 1'b1;
            end
        end
    end
endmodule

/* verification/testbench.sv */
// Self-checking bench of the soft power wake and delay block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_fail++; $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module testbench;
    import spw_pkg::*;
    localparam int unsigned STEP = 8;
    typedef struct {string nm; logic [7:0] e; bit acc;} spw_note_s;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack, pwr_n;
    logic [3:0]  pulse = 4'h0;
    logic [3:0]  pin_n;
    logic [7:0]  acc_r = 8'h00;
    logic [31:0] seed = 32'd56064;
    int          n_fail = 0, check_count = 0, cnt;
    spw_note_s   q[$], nt;
    logic [3:0]  m;

    always #2 clk_i = ~clk_i;

    spw_top #(.STEP_CYCLES(STEP)) i_spw_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .uart_a_rxd_i(pin_n[0]),
        .uart_b_rxd_i(pin_n[1]), .power_button_n_i(pin_n[2]),
        .ring_indicator_pin_n_i(pin_n[3]), .power_on_request_n_o(pwr_n));

    spw_pin_model i_spw_pin_model (
        .clk_i(clk_i), .pulse_i(pulse), .pin_n_o(pin_n));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // ==================================================================
    // Bus tasks: hold the request until ack is sampled, then release
    task automatic wb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h000000, d};
        sel <= s;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 100) n_fail++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'hF);
    endtask

    // Accumulating reads are merged with the next plain read of status
    task automatic rd(input string nm, input logic [7:0] idx,
                      input logic [7:0] e, input bit a = 0);
        q.push_back('{nm, e, a});
        wb(1'b0, idx, 8'h00, 4'hF);
    endtask

    task automatic pulse_pins(input logic [3:0] pm);
        @(posedge clk_i);
        pulse <= pm;
        @(posedge clk_i);
        pulse <= 4'h0;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // ==================================================================
    // Monitor: every read answer takes the oldest note; accumulating notes OR it in, plain notes compare it
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
            nt = q.pop_front();
            if (nt.acc) begin
                acc_r = acc_r | dat_o[7:0];
            end else begin
                `CHK(nt.nm, nt.e, acc_r | dat_o[7:0])
                acc_r = 8'h00;
            end
        end
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        wait_cyc(20000);
        n_fail++;
        test_done();
    end

    // ==================================================================
    // Main sequence
    initial begin
        wait_cyc(5);
        rst_i <= 1'b0;
        rd("enable_rst", SPW_IDX_ENABLE, 8'h80);
        rd("status_rst", SPW_IDX_STATUS, 8'h00);
        rd("delay_rst", SPW_IDX_DELAY, 8'h00);
        rd("ctrl_rst", SPW_IDX_CTRL, 8'h00);
        `CHK("pwr_rst", 1'b1, pwr_n)
        wr(8'h10, 8'hFF);
        rd("unmapped", 8'h10, 8'h00);
        wr(SPW_IDX_DELAY, 8'hFF);
        rd("delay_field", SPW_IDX_DELAY, 8'h3F);
        wb(1'b1, SPW_IDX_DELAY, 8'h02, 4'hE);
        rd("delay_sel0", SPW_IDX_DELAY, 8'h3F);
        wr(SPW_IDX_DELAY, 8'h02);
        wr(SPW_IDX_STATUS, 8'hFF);
        rd("status_ro", SPW_IDX_STATUS, 8'h00);
        // Ring while its wake is disabled: latched, but power stays off
        pulse_pins(4'h8);
        wait_cyc(12);
        `CHK("pwr_ring_dis", 1'b1, pwr_n)
        rd("ring_flag", SPW_IDX_STATUS, 8'h08);
        rd("ring_clr", SPW_IDX_STATUS, 8'h00);
        wr(SPW_IDX_ENABLE, 8'h89);
        pulse_pins(4'h8);
        wait_cyc(12);
        `CHK("pwr_ring_en", 1'b0, pwr_n)
        rd("ring_flag2", SPW_IDX_STATUS, 8'h08);
        // Button with delay select off must not power down
        pulse_pins(4'h4);
        wait_cyc(60);
        `CHK("pwr_no_sel", 1'b0, pwr_n)
        rd("button_flag", SPW_IDX_STATUS, 8'h04);
        wr(SPW_IDX_ENABLE, 8'h09);
        wr(SPW_IDX_CTRL, 8'h01);
        pulse_pins(4'h4);
        wait_cyc(60);
        `CHK("pwr_no_offen", 1'b0, pwr_n)
        rd("button_flag2", SPW_IDX_STATUS, 8'h04);
        // Timed power-off with code 2: three steps plus pin latency
        wr(SPW_IDX_ENABLE, 8'h89);
        pulse_pins(4'h4);
        cnt = 0;
        while (pwr_n !== 1'b1 && cnt < 200) begin
            @(posedge clk_i);
            cnt++;
        end
        `CHK("off_min", 1'b1, cnt >= 3 * STEP)
        `CHK("off_max", 1'b1, cnt <= 3 * STEP + 8)
        rd("button_flag3", SPW_IDX_STATUS, 8'h04);
        // Receive line B not enabled, then line A enabled
        pulse_pins(4'h2);
        wait_cyc(12);
        `CHK("pwr_b_dis", 1'b1, pwr_n)
        rd("uart_b_flag", SPW_IDX_STATUS, 8'h02);
        pulse_pins(4'h1);
        wait_cyc(12);
        `CHK("pwr_a_en", 1'b0, pwr_n)
        rd("uart_a_flag", SPW_IDX_STATUS, 8'h01);
        // Random events racing status reads; none may be lost
        wr(SPW_IDX_CTRL, 8'h00);
        for (int i = 0; i < 40; i++) begin
            m = 4'(rnd());
            pulse_pins(m);
            wait_cyc(1 + rnd() % 8);
            rd("race_a", SPW_IDX_STATUS, 8'h00, 1);
            wait_cyc(12);
            rd("race_b", SPW_IDX_STATUS, {4'h0, m});
        end
        wait_cyc(4);
        test_done();
    end
endmodule
